// file: gain_defines.svh
// offsets, field positions, reset values for the channel 0-3 gain register
`ifndef GAIN_DEFINES_SVH
`define GAIN_DEFINES_SVH
`define GAIN_REG_ADDR      8'h04
`define GAIN_REG_RESET     16'h0000
`define GAIN_CODE_RESET    3'h0
`define GAIN_CH0_LSB       0
`define GAIN_CH1_LSB       4
`define GAIN_CH2_LSB       8
`define GAIN_CH3_LSB       12
`define GAIN_RSVD_MASK     16'h8888
`define GAIN_FIELD_STRIDE  4
`endif

// file: gain_pkg.sv
// types shared by the gain register bank
package gain_pkg;
    typedef logic [2:0] gain_code_t;
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;
    typedef struct packed {
        gain_code_t ch3;
        gain_code_t ch2;
        gain_code_t ch1;
        gain_code_t ch0;
    } gain_codes_s;
endpackage

// file: gain_decode.sv
// one-hot power-of-two decoder for a single gain code
module gain_decode (
    input  wire logic [2:0] code_i,  // gain code
    output logic      [7:0] gain_o   // linear gain 1..128
);
    // code n gives gain 2**n
    assign gain_o = 8'h01 << code_i;
endmodule

// file: reset_sync.sv
// reset release synchroniser
module reset_sync (
    input  wire logic clock_i,  // clock
    input  wire logic rstn_i,   // async reset, active low
    output logic      rstn_o    // synchronised reset
);
    logic [1:0] sync_ff;
    // assert at once, release after two edges
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_ff <= 2'h0;
        end else begin
            sync_ff <= {sync_ff[0], 1'b1};
        end
    end
    assign rstn_o = sync_ff[1];
endmodule

// file: gain_select_bank.sv
// gain register bank for channels 0 to 3
//
// Chosen here: the strobed register port.
`include "gain_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - register sits at address 4h and resets to 0000h, unity gain.
// - bits 14:12 hold channel 3 gain code, read/write, reset 000b.
// - bits 10:8 hold channel 2 gain code, read/write, reset 000b.
// - bits 6:4 hold channel 1 gain code, read/write, reset 000b.
// - gain code n decodes to gain two to the n, 1 to 128.
// - bits 15, 11, 7, 3 reserved, reset 0, read/write; write 0.
module gain_select_bank (
    input  wire logic                 clock_i,   // 250 MHz clock
    input  wire logic                 rstn_i,    // async reset, active low
    input  wire logic                 ce_i,      // clock enable
    input  wire logic [7:0]           addr_i,    // register address
    input  wire logic [15:0]          wdata_i,   // write data
    input  wire logic                 wr_i,      // write strobe
    input  wire logic                 rd_i,      // read strobe
    output logic      [15:0]          rdata_o,   // read data, cycle after rd
    output gain_pkg::gain_codes_s     codes_o,   // gain codes per channel
    output logic      [31:0]          gains_o    // linear gains, ch3 high byte
);
    logic                 rstn_sync;
    gain_pkg::reg_req_s   req;
    logic [15:0]          gain_select_ch0_to_ch3_ff;
    logic [15:0]          rdata_ff;
    logic                 hit;

    ////////////////////////////////////////////////////////////////////////////
    // reset release
    reset_sync u_rst (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .rstn_o  (rstn_sync)
    );

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign hit = (req.addr == `GAIN_REG_ADDR);

    ////////////////////////////////////////////////////////////////////////////
    // register store; reserved bits kept as written, software must write 0
    always_ff @(posedge clock_i or negedge rstn_sync) begin
        if (!rstn_sync) begin
            gain_select_ch0_to_ch3_ff <= `GAIN_REG_RESET;
        end else if (ce_i && req.wr && hit) begin
            gain_select_ch0_to_ch3_ff <= req.wdata;
        end
    end

    // read data valid from the cycle after the strobe until the next enabled edge; unmapped reads give 0
    always_ff @(posedge clock_i or negedge rstn_sync) begin
        if (!rstn_sync) begin
            rdata_ff <= 16'h0000;
        end else if (ce_i) begin
            if (req.rd && hit) begin
                rdata_ff <= gain_select_ch0_to_ch3_ff;
            end else begin
                rdata_ff <= 16'h0000;
            end
        end
    end
    assign rdata_o = rdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // field extraction
    assign codes_o.ch0 = gain_select_ch0_to_ch3_ff[`GAIN_CH0_LSB +: 3];
    assign codes_o.ch1 = gain_select_ch0_to_ch3_ff[`GAIN_CH1_LSB +: 3];
    assign codes_o.ch2 = gain_select_ch0_to_ch3_ff[`GAIN_CH2_LSB +: 3];
    assign codes_o.ch3 = gain_select_ch0_to_ch3_ff[`GAIN_CH3_LSB +: 3];

    // one decoder per channel
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_dec
            gain_decode u_dec (
                .code_i (gain_select_ch0_to_ch3_ff[g*`GAIN_FIELD_STRIDE +: 3]),
                .gain_o (gains_o[g*8 +: 8])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_reset_value;
        @(posedge clock_i) $rose(rstn_sync) |-> gain_select_ch0_to_ch3_ff == `GAIN_REG_RESET;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("bad reset value");

    sequence s_write;
        ce_i && wr_i && addr_i == `GAIN_REG_ADDR;
    endsequence
    property p_write_rd;
        @(posedge clock_i) disable iff (!rstn_sync)
            s_write ##1 (ce_i && rd_i && addr_i == `GAIN_REG_ADDR && !wr_i)
            |=> rdata_o == $past(wdata_i, 2);
    endproperty
    a_write_rd: assert property (p_write_rd) else $error("readback mismatch");

    property p_ch3;
        @(posedge clock_i) disable iff (!rstn_sync) s_write |=> codes_o.ch3 == $past(wdata_i[14:12]);
    endproperty
    a_ch3: assert property (p_ch3) else $error("ch3 field wrong");

    property p_ch2;
        @(posedge clock_i) disable iff (!rstn_sync) s_write |=> codes_o.ch2 == $past(wdata_i[10:8]);
    endproperty
    a_ch2: assert property (p_ch2) else $error("ch2 field wrong");

    property p_ch1;
        @(posedge clock_i) disable iff (!rstn_sync) s_write |=> codes_o.ch1 == $past(wdata_i[6:4]);
    endproperty
    a_ch1: assert property (p_ch1) else $error("ch1 field wrong");

    property p_ch0;
        @(posedge clock_i) disable iff (!rstn_sync) s_write |=> codes_o.ch0 == $past(wdata_i[2:0]);
    endproperty
    a_ch0: assert property (p_ch0) else $error("ch0 field wrong");

    property p_decode;
        @(posedge clock_i) disable iff (!rstn_sync) gains_o[31:24] == (8'h01 << codes_o.ch3);
    endproperty
    a_decode: assert property (p_decode) else $error("gain decode wrong");

    property p_hold;
        @(posedge clock_i) disable iff (!rstn_sync)
            !(ce_i && wr_i) |=> $stable(gain_select_ch0_to_ch3_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without write");

    ////////////////////////////////////////////////////////////////////////////
    // read path, write path, clock enable, decoder and reset checks
    // each strobe is judged one edge later, when the flops have moved

    // a read strobe aimed at the register
    sequence s_read;
        ce_i && rd_i && addr_i == `GAIN_REG_ADDR;
    endsequence

    // a read strobe aimed anywhere else
    sequence s_miss_read;
        ce_i && rd_i && addr_i != `GAIN_REG_ADDR;
    endsequence

    // read returns the stored word in the next cycle
    property p_read_data;
        @(posedge clock_i) disable iff (!rstn_sync)
            s_read |=> rdata_o == $past(gain_select_ch0_to_ch3_ff);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data wrong");

    // reserved bits come back exactly as stored
    property p_rdata_rsvd;
        @(posedge clock_i) disable iff (!rstn_sync)
            s_read |=> (rdata_o & `GAIN_RSVD_MASK) == ($past(gain_select_ch0_to_ch3_ff) & `GAIN_RSVD_MASK);
    endproperty
    a_rdata_rsvd: assert property (p_rdata_rsvd) else $error("reserved read bits wrong");

    // unmapped reads give zero, so software sees no ghost copy
    property p_read_miss;
        @(posedge clock_i) disable iff (!rstn_sync)
            s_miss_read |=> rdata_o == 16'h0000;
    endproperty
    a_read_miss: assert property (p_read_miss) else $error("unmapped read not zero");

    // read data stands one enabled cycle only
    property p_read_idle;
        @(posedge clock_i) disable iff (!rstn_sync)
            ce_i && !rd_i |=> rdata_o == 16'h0000;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data lingers");

    // a write elsewhere must not touch the word
    property p_miss_write;
        @(posedge clock_i) disable iff (!rstn_sync)
            ce_i && wr_i && addr_i != `GAIN_REG_ADDR |=> $stable(gain_select_ch0_to_ch3_ff);
    endproperty
    a_miss_write: assert property (p_miss_write) else $error("unmapped write landed");

    // reserved bits are stored as written
    property p_rsvd_store;
        @(posedge clock_i) disable iff (!rstn_sync)
            s_write |=> (gain_select_ch0_to_ch3_ff & `GAIN_RSVD_MASK) == ($past(wdata_i) & `GAIN_RSVD_MASK);
    endproperty
    a_rsvd_store: assert property (p_rsvd_store) else $error("reserved bits not stored");

    // clock enable low freezes the register
    property p_ce_reg;
        @(posedge clock_i) disable iff (!rstn_sync)
            !ce_i |=> $stable(gain_select_ch0_to_ch3_ff);
    endproperty
    a_ce_reg: assert property (p_ce_reg) else $error("register moved with enable low");

    // clock enable low also freezes the read flop
    property p_ce_rdata;
        @(posedge clock_i) disable iff (!rstn_sync)
            !ce_i |=> $stable(rdata_o);
    endproperty
    a_ce_rdata: assert property (p_ce_rdata) else $error("read data moved with enable low");

    // a write while frozen leaves the codes alone
    property p_ce_write;
        @(posedge clock_i) disable iff (!rstn_sync)
            !ce_i && wr_i |=> $stable(codes_o);
    endproperty
    a_ce_write: assert property (p_ce_write) else $error("frozen write changed codes");

    // remaining decoders, one byte per channel
    property p_decode_ch2;
        @(posedge clock_i) disable iff (!rstn_sync)
            gains_o[23:16] == (8'h01 << codes_o.ch2);
    endproperty
    a_decode_ch2: assert property (p_decode_ch2) else $error("ch2 gain decode wrong");

    // channel 1 decoder
    property p_decode_ch1;
        @(posedge clock_i) disable iff (!rstn_sync)
            gains_o[15:8] == (8'h01 << codes_o.ch1);
    endproperty
    a_decode_ch1: assert property (p_decode_ch1) else $error("ch1 gain decode wrong");

    // channel 0 decoder
    property p_decode_ch0;
        @(posedge clock_i) disable iff (!rstn_sync)
            gains_o[7:0] == (8'h01 << codes_o.ch0);
    endproperty
    a_decode_ch0: assert property (p_decode_ch0) else $error("ch0 gain decode wrong");

    // a power of two has exactly one bit set
    property p_onehot_ch0;
        @(posedge clock_i) disable iff (!rstn_sync)
            $onehot(gains_o[7:0]);
    endproperty
    a_onehot_ch0: assert property (p_onehot_ch0) else $error("ch0 gain not a power of two");

    // channel 1 power of two
    property p_onehot_ch1;
        @(posedge clock_i) disable iff (!rstn_sync)
            $onehot(gains_o[15:8]);
    endproperty
    a_onehot_ch1: assert property (p_onehot_ch1) else $error("ch1 gain not a power of two");

    // channel 2 power of two
    property p_onehot_ch2;
        @(posedge clock_i) disable iff (!rstn_sync)
            $onehot(gains_o[23:16]);
    endproperty
    a_onehot_ch2: assert property (p_onehot_ch2) else $error("ch2 gain not a power of two");

    // channel 3 power of two
    property p_onehot_ch3;
        @(posedge clock_i) disable iff (!rstn_sync)
            $onehot(gains_o[31:24]);
    endproperty
    a_onehot_ch3: assert property (p_onehot_ch3) else $error("ch3 gain not a power of two");

    // while held in reset the word is at its reset value
    property p_rst_reg;
        @(posedge clock_i)
            !rstn_sync |-> gain_select_ch0_to_ch3_ff == `GAIN_REG_RESET;
    endproperty
    a_rst_reg: assert property (p_rst_reg) else $error("register not cleared in reset");

    // no stale read data during reset
    property p_rst_rdata;
        @(posedge clock_i)
            !rstn_sync |-> rdata_o == 16'h0000;
    endproperty
    a_rst_rdata: assert property (p_rst_rdata) else $error("read data not cleared in reset");

    // every channel at unity gain during reset
    property p_rst_gains;
        @(posedge clock_i)
            !rstn_sync |-> gains_o == 32'h01010101;
    endproperty
    a_rst_gains: assert property (p_rst_gains) else $error("gains not unity in reset");

    // channel 3 code resets to zero
    property p_rst_ch3;
        @(posedge clock_i)
            !rstn_sync |-> codes_o.ch3 == `GAIN_CODE_RESET;
    endproperty
    a_rst_ch3: assert property (p_rst_ch3) else $error("ch3 code not reset");

    // channel 2 code resets to zero
    property p_rst_ch2;
        @(posedge clock_i)
            !rstn_sync |-> codes_o.ch2 == `GAIN_CODE_RESET;
    endproperty
    a_rst_ch2: assert property (p_rst_ch2) else $error("ch2 code not reset");

    // channel 1 code resets to zero
    property p_rst_ch1;
        @(posedge clock_i)
            !rstn_sync |-> codes_o.ch1 == `GAIN_CODE_RESET;
    endproperty
    a_rst_ch1: assert property (p_rst_ch1) else $error("ch1 code not reset");

    // channel 0 code resets to zero
    property p_rst_ch0;
        @(posedge clock_i)
            !rstn_sync |-> codes_o.ch0 == `GAIN_CODE_RESET;
    endproperty
    a_rst_ch0: assert property (p_rst_ch0) else $error("ch0 code not reset");
endmodule

// file: pga_gain_select_ch0_3_test.sv
// self-checking bench for the channel 0-3 gain register bank
module pga_gain_select_ch0_3_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clock_i     = 1'b0;
    logic                  rstn_i      = 1'b0;
    logic                  ce_i        = 1'b1;
    logic [7:0]            addr_i      = 8'h00;
    logic [15:0]           wdata_i     = 16'h0000;
    logic                  wr_i        = 1'b0;
    logic                  rd_i        = 1'b0;
    logic [15:0]           rdata_o;
    gain_pkg::gain_codes_s codes_o;
    logic [31:0]           gains_o;
    int                    num_errors  = 0;
    int                    check_count = 0;
    logic [15:0]           v;
    logic [15:0]           r;
    ////////////////////////////////////////////////////////////////////////////
    // 250 MHz clock
    always #2 clock_i = ~clock_i;
    gain_select_bank i_dut (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .codes_o(codes_o),
        .gains_o(gains_o));
    ////////////////////////////////////////////////////////////////////////////
    // compare helper and verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // bus cycles: strobes one cycle, first request three edges after release
    task automatic do_reset();
        rstn_i <= 1'b0;
        repeat (10) @(posedge clock_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clock_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock_i) begin addr_i <= a; wdata_i <= d; wr_i <= 1'b1; end
        @(posedge clock_i) wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock_i) begin addr_i <= a; rd_i <= 1'b1; end
        @(posedge clock_i) rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        check(32'(codes_o), 32'h0);
        check(gains_o, 32'h01010101);
        rd(8'h04, r);
        check(32'(r), 32'h0);
    endtask
    task automatic t_fields();
        for (int k = 0; k < 8; k++) begin
            v = {1'b0, 3'(k + 3), 1'b0, 3'(k + 2), 1'b0, 3'(k + 1), 1'b0, 3'(k)};
            wr(8'h04, v);
            check(32'(codes_o), 32'({v[14:12], v[10:8], v[6:4], v[2:0]}));
            check(gains_o, {8'h01 << v[14:12], 8'h01 << v[10:8], 8'h01 << v[6:4], 8'h01 << v[2:0]});
            rd(8'h04, r);
            check(32'(r), 32'(v));
        end
    endtask
    // reserved bits kept as written, cleared by a mid-run reset
    task automatic t_rsvd();
        wr(8'h04, 16'hffff);
        rd(8'h04, r);
        check(32'(r), 32'hffff);
        do_reset();
        rd(8'h04, r);
        check(32'(r), 32'h0);
    endtask
    // other addresses and a frozen clock enable must leave the word alone
    task automatic t_refuse();
        wr(8'h04, 16'h1234);
        wr(8'h05, 16'h7777);
        wr(8'h84, 16'h7777);
        rd(8'h03, r);
        check(32'(r), 32'h0);
        ce_i <= 1'b0;
        wr(8'h04, 16'h5555);
        ce_i <= 1'b1;
        rd(8'h04, r);
        check(32'(r), 32'h1234);
    endtask
    // write then read with no gap; data stands one cycle only
    task automatic t_b2b();
        @(posedge clock_i) begin addr_i <= 8'h04; wdata_i <= 16'h4321; wr_i <= 1'b1; end
        @(posedge clock_i) begin wr_i <= 1'b0; rd_i <= 1'b1; end
        @(posedge clock_i) rd_i <= 1'b0;
        #1 check(32'(rdata_o), 32'h4321);
        @(posedge clock_i) #1 check(32'(rdata_o), 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog, both end in summarize
    initial begin
        do_reset();
        t_reset();
        t_fields();
        t_rsvd();
        t_refuse();
        t_b2b();
        summarize();
    end
    initial begin
        #20000;
        num_errors++;
        summarize();
    end
endmodule
